// ===== verilog/ssbc_pkg.sv
package ssbc_pkg;
  // Register offsets (word addresses on the host port)
  localparam logic [7:0] SYSTEM_FAULT_STATUS_OFS = 8'h0C;
  localparam logic [7:0] SYSTEM_INTERRUPT_MASK_OFS = 8'h0D;
  localparam logic [7:0] BOOT_STRAP_HIGH_OFS = 8'h14;
  localparam logic [7:0] BOOT_STRAP_LOW_OFS = 8'h15;
  localparam logic [7:0] RESET_CAUSE_OFS = 8'h16;
  localparam logic [7:0] ENTRY_ADDRESS_HIGH_OFS = 8'h18;
  localparam logic [7:0] ENTRY_ADDRESS_LOW_OFS = 8'h19;
  localparam logic [7:0] SOFTWARE_FLAGS_OFS = 8'h1A;
  localparam logic [7:0] BOOT_STATUS_OFS = 8'h1B;

  // Field positions shared by status and mask
  localparam int EVENT_DELAY_BIT = 15;
  localparam int OVERFLOW_BIT = 14;
  localparam int WATCHDOG_BIT = 13;
  localparam int PLL_FAIL_BIT = 12;
  localparam int HIGHWAY_A_FAIL_BIT = 11;
  localparam int HIGHWAY_B_FAIL_BIT = 10;
  localparam int SW_FLAG_MSB = 9;
  localparam int SW_FLAG_COUNT = 10;

  // Strap pin positions inside the high strap word
  localparam int STRAP_SLOW_SPEED_BIT = 15;
  localparam int STRAP_SKIP_CLOCK_WAIT_BIT = 14;
  localparam int STRAP_SELFTEST_OFF_BIT = 13;
  localparam int STRAP_DEBUG_BIT = 12;
  localparam int STRAP_UART_BIT = 11;
  localparam int STRAP_MESSAGES_BIT = 10;

  // Reset values
  localparam logic [15:0] SYSTEM_INTERRUPT_MASK_RST = 16'h7FFF;
  localparam logic [2:0] CLOCK_FAIL_RST = 3'h7;
  localparam logic [SW_FLAG_COUNT-1:0] SW_FLAGS_RST = 10'h000;

  // Strap settle time before sampling
  localparam int CLK_FREQ_KHZ = 10000;
  localparam int STRAP_SETTLE_US = 200;
  localparam int STRAP_SETTLE_CYCLES = (STRAP_SETTLE_US * CLK_FREQ_KHZ + 999) / 1000;

  typedef enum logic [2:0] {
    SSBC_SETTLE = 3'b000,
    SSBC_PLL = 3'b001,
    SSBC_CLOCK_WAIT = 3'b010,
    SSBC_SELFTEST = 3'b011,
    SSBC_DEBUG = 3'b100,
    SSBC_DONE = 3'b101
  } ssbc_boot_e;
endpackage

// ===== verilog/ssbc_delay_timer.sv
`timescale 1ns/10ps
module ssbc_delay_timer #(
  parameter int COUNT = 2000,
  parameter int WIDTH = 12
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  output logic expired_o
);
  logic [WIDTH-1:0] remaining;
  logic running;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      remaining <= '0;
      running <= 1'b0;
    end else if (start_i) begin
      remaining <= WIDTH'(COUNT - 1);
      running <= 1'b1;
    end else if (running && remaining != '0) begin
      remaining <= remaining - 1'b1;
    end else begin
      running <= 1'b0;
    end
  end

  assign expired_o = running && (remaining == '0);
endmodule

// ===== verilog/ssbc_system_regs.sv
`timescale 1ns/10ps
module ssbc_system_regs #(
  parameter int SETTLE_CYCLES = ssbc_pkg::STRAP_SETTLE_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [15:0] reg_rdata_o,
  input wire logic interrupt_indication_read_i,
  input wire logic event_discard_i,
  input wire logic queue1_pending_i,
  input wire logic queue23_pending_i,
  input wire logic watchdog_output_pin_i,
  input wire logic system_reset_i,
  input wire logic pll_clock_fail_i,
  input wire logic highway_a_clock_fail_i,
  input wire logic highway_b_clock_fail_i,
  input wire logic [31:0] gpio_i,
  input wire logic [3:0] reset_cause_bits_i,
  input wire logic selftest_done_i,
  input wire logic debug_release_i,
  output logic host_interrupt_n_o,
  output logic low_queue_release_o,
  output logic system_interrupt_o,
  output logic core_hold_o,
  output logic pll_max_speed_o,
  output logic selftest_start_o,
  output logic debug_mode_o,
  output logic uart_cli_enable_o,
  output logic gpio_messages_enable_o,
  output logic [31:0] program_entry_address_o
);
  import ssbc_pkg::*;

  logic event_overflow_flag;
  logic watchdog_expired_flag;
  logic [2:0] clock_fail;
  logic [SW_FLAG_COUNT-1:0] software_system_flags;
  logic [SW_FLAG_COUNT-1:0] sw_flag_changed;
  logic [15:0] system_interrupt_mask;
  logic [15:0] boot_strap_high;
  logic [15:0] boot_strap_low;
  logic [3:0] reset_cause;
  logic [15:0] entry_address_high;
  logic [15:0] entry_address_low;
  logic watchdog_pin_prev;
  logic low_queue_armed;
  logic strap_taken;
  logic settle_start;
  logic settle_expired;
  ssbc_boot_e boot_state;
  ssbc_boot_e next_boot_state;
  logic [15:0] fault_status;
  logic [15:0] irq_sources;
  logic wr_mask;
  logic rd_status;
  logic status_read_clear_ovl;
  logic status_read_clear_wdt;
  logic ind_read_clear_ovl;
  logic ind_read_clear_wdt;

  function automatic logic hit(input logic strobe, input logic [7:0] addr,
                               input logic [7:0] ofs);
    hit = strobe && (addr == ofs);
  endfunction

  assign wr_mask = hit(reg_write_i, reg_addr_i, SYSTEM_INTERRUPT_MASK_OFS);
  assign rd_status = hit(reg_read_i, reg_addr_i, SYSTEM_FAULT_STATUS_OFS);

  always_comb begin
    fault_status = 16'h0000;
    fault_status[OVERFLOW_BIT] = event_overflow_flag;
    fault_status[WATCHDOG_BIT] = watchdog_expired_flag;
    fault_status[PLL_FAIL_BIT] = clock_fail[2];
    fault_status[HIGHWAY_A_FAIL_BIT] = clock_fail[1];
    fault_status[HIGHWAY_B_FAIL_BIT] = clock_fail[0];
    fault_status[SW_FLAG_MSB:0] = software_system_flags;
  end

  // clear source depends on mask state
  assign status_read_clear_ovl = rd_status && system_interrupt_mask[OVERFLOW_BIT];
  assign status_read_clear_wdt = rd_status && system_interrupt_mask[WATCHDOG_BIT];
  assign ind_read_clear_ovl = interrupt_indication_read_i
                              && !system_interrupt_mask[OVERFLOW_BIT];
  assign ind_read_clear_wdt = interrupt_indication_read_i
                              && !system_interrupt_mask[WATCHDOG_BIT];

  // set wins over a simultaneous clear
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      event_overflow_flag <= 1'b0;
    end else if (event_discard_i) begin
      event_overflow_flag <= 1'b1;
    end else if (status_read_clear_ovl || ind_read_clear_ovl) begin
      event_overflow_flag <= 1'b0;
    end
  end

  // falling pin edge that did not reset the system
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      watchdog_pin_prev <= 1'b1;
      watchdog_expired_flag <= 1'b0;
    end else begin
      watchdog_pin_prev <= watchdog_output_pin_i;
      if (watchdog_pin_prev && !watchdog_output_pin_i && !system_reset_i) begin
        watchdog_expired_flag <= 1'b1;
      end else if (status_read_clear_wdt || ind_read_clear_wdt) begin
        watchdog_expired_flag <= 1'b0;
      end
    end
  end

  // failure indicators read failed until the first sample
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clock_fail <= CLOCK_FAIL_RST;
    end else begin
      clock_fail <= {pll_clock_fail_i, highway_a_clock_fail_i, highway_b_clock_fail_i};
    end
  end

  // software flags written by firmware, edges latched
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      software_system_flags <= SW_FLAGS_RST;
      sw_flag_changed <= '0;
    end else begin
      if (hit(reg_write_i, reg_addr_i, SOFTWARE_FLAGS_OFS)) begin
        software_system_flags <= reg_wdata_i[SW_FLAG_MSB:0];
        // New transitions win over the clear below
        sw_flag_changed <= sw_flag_changed
                           | (software_system_flags ^ reg_wdata_i[SW_FLAG_MSB:0]);
      end else if (interrupt_indication_read_i) begin
        sw_flag_changed <= '0;
      end
    end
  end

  // all mask bits reset masked, defer bit clear
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      system_interrupt_mask <= SYSTEM_INTERRUPT_MASK_RST;
    end else if (wr_mask) begin
      system_interrupt_mask <= reg_wdata_i;
    end
  end

  // same bit positions in status and mask
  always_comb begin
    irq_sources = fault_status;
    irq_sources[EVENT_DELAY_BIT] = 1'b0;
    irq_sources[SW_FLAG_MSB:0] = sw_flag_changed;
  end

  assign system_interrupt_o = |(irq_sources & ~system_interrupt_mask);

  // arming by a system or queue-one interrupt
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_queue_armed <= 1'b0;
    end else if (system_interrupt_o || queue1_pending_i) begin
      low_queue_armed <= 1'b1;
    end else if (!queue23_pending_i) begin
      low_queue_armed <= 1'b0;
    end
  end

  // defer off lets low queues through directly
  assign low_queue_release_o = !system_interrupt_mask[EVENT_DELAY_BIT]
                               || low_queue_armed || system_interrupt_o
                               || queue1_pending_i;
  assign host_interrupt_n_o = !(system_interrupt_o || queue1_pending_i
                                || (queue23_pending_i && low_queue_release_o));

  ssbc_delay_timer #(
    .COUNT(SETTLE_CYCLES),
    .WIDTH($clog2(SETTLE_CYCLES + 1))
  ) u_settle (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .start_i(settle_start),
    .expired_o(settle_expired)
  );

  // boot entered on every reset release
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_taken <= 1'b0;
      settle_start <= 1'b0;
    end else begin
      settle_start <= !strap_taken;
      strap_taken <= 1'b1;
    end
  end

  // wait out the settle time before the straps
  always_comb begin
    next_boot_state = boot_state;
    unique case (boot_state)
      SSBC_SETTLE: begin
        if (settle_expired) begin
          next_boot_state = SSBC_PLL;
        end
      end
      SSBC_PLL: begin
        next_boot_state = SSBC_CLOCK_WAIT;
      end
      // hold for a good clock unless skipped
      SSBC_CLOCK_WAIT: begin
        if (boot_strap_high[STRAP_SKIP_CLOCK_WAIT_BIT] || !clock_fail[2]) begin
          next_boot_state = SSBC_SELFTEST;
        end
      end
      SSBC_SELFTEST: begin
        if (boot_strap_high[STRAP_SELFTEST_OFF_BIT] || selftest_done_i) begin
          next_boot_state = SSBC_DEBUG;
        end
      end
      // debug stop only with strap high
      SSBC_DEBUG: begin
        if (!boot_strap_high[STRAP_DEBUG_BIT] || debug_release_i) begin
          next_boot_state = SSBC_DONE;
        end
      end
      SSBC_DONE: begin
        next_boot_state = SSBC_DONE;
      end
      default: begin
        next_boot_state = SSBC_SETTLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      boot_state <= SSBC_SETTLE;
    end else begin
      boot_state <= next_boot_state;
    end
  end

  // pins sampled once the settle time is over
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      boot_strap_high <= 16'h0000;
      boot_strap_low <= 16'h0000;
    end else if (boot_state == SSBC_SETTLE && settle_expired) begin
      boot_strap_high <= gpio_i[31:16];
      boot_strap_low <= gpio_i[15:0];
    end else begin
      if (hit(reg_write_i, reg_addr_i, BOOT_STRAP_HIGH_OFS)) begin
        boot_strap_high <= reg_wdata_i;
      end
      if (hit(reg_write_i, reg_addr_i, BOOT_STRAP_LOW_OFS)) begin
        boot_strap_low <= reg_wdata_i;
      end
    end
  end

  // cause nibble taken when boot starts
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reset_cause <= 4'h0;
    end else if (!strap_taken) begin
      reset_cause <= reset_cause_bits_i;
    end
  end

  // host-written entry address, held for launch
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      entry_address_high <= 16'h0000;
      entry_address_low <= 16'h0000;
    end else begin
      if (hit(reg_write_i, reg_addr_i, ENTRY_ADDRESS_HIGH_OFS)) begin
        entry_address_high <= reg_wdata_i;
      end
      if (hit(reg_write_i, reg_addr_i, ENTRY_ADDRESS_LOW_OFS)) begin
        entry_address_low <= reg_wdata_i;
      end
    end
  end

  assign program_entry_address_o = {entry_address_high, entry_address_low};

  // Boot outputs registered so they never glitch
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      core_hold_o <= 1'b1;
      pll_max_speed_o <= 1'b0;
      selftest_start_o <= 1'b0;
      debug_mode_o <= 1'b0;
      uart_cli_enable_o <= 1'b0;
      gpio_messages_enable_o <= 1'b0;
    end else begin
      // core released only at the end
      core_hold_o <= (next_boot_state != SSBC_DONE);
      // maximum PLL only when strap is low
      if (boot_state == SSBC_PLL) begin
        pll_max_speed_o <= !boot_strap_high[STRAP_SLOW_SPEED_BIT];
      end
      selftest_start_o <= (boot_state == SSBC_CLOCK_WAIT)
                          && (next_boot_state == SSBC_SELFTEST)
                          && !boot_strap_high[STRAP_SELFTEST_OFF_BIT];
      debug_mode_o <= (next_boot_state == SSBC_DEBUG)
                      && boot_strap_high[STRAP_DEBUG_BIT];
      // console and messages only while booting
      uart_cli_enable_o <= (boot_state != SSBC_SETTLE) && (next_boot_state != SSBC_DONE)
                           && boot_strap_high[STRAP_UART_BIT];
      gpio_messages_enable_o <= (boot_state != SSBC_SETTLE)
                                && (next_boot_state != SSBC_DONE)
                                && boot_strap_high[STRAP_MESSAGES_BIT];
    end
  end

  // Read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_read_i) begin
      unique case (reg_addr_i)
        SYSTEM_FAULT_STATUS_OFS: reg_rdata_o <= fault_status;
        SYSTEM_INTERRUPT_MASK_OFS: reg_rdata_o <= system_interrupt_mask;
        BOOT_STRAP_HIGH_OFS: reg_rdata_o <= boot_strap_high;
        BOOT_STRAP_LOW_OFS: reg_rdata_o <= boot_strap_low;
        RESET_CAUSE_OFS: reg_rdata_o <= {12'h000, reset_cause};
        ENTRY_ADDRESS_HIGH_OFS: reg_rdata_o <= entry_address_high;
        ENTRY_ADDRESS_LOW_OFS: reg_rdata_o <= entry_address_low;
        SOFTWARE_FLAGS_OFS: reg_rdata_o <= {6'h00, software_system_flags};
        BOOT_STATUS_OFS: reg_rdata_o <= {13'h0000, boot_state};
        default: reg_rdata_o <= 16'h0000;
      endcase
    end else begin
      reg_rdata_o <= 16'h0000;
    end
  end
endmodule

// ===== tb/ssbc_system_regs_asserts.sv
`timescale 1ns/10ps
module ssbc_system_regs_asserts #(
  parameter int SETTLE_CYCLES = 2000
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic event_discard_i,
  input wire logic queue1_pending_i,
  input wire logic queue23_pending_i,
  input wire logic watchdog_output_pin_i,
  input wire logic system_reset_i,
  input wire logic pll_clock_fail_i,
  input wire logic highway_a_clock_fail_i,
  input wire logic highway_b_clock_fail_i,
  input wire logic host_interrupt_n_o,
  input wire logic low_queue_release_o,
  input wire logic system_interrupt_o,
  input wire logic core_hold_o,
  input wire logic [31:0] program_entry_address_o
);
  logic [15:0] mask_copy;
  logic [15:0] boot_cnt;
  logic [2:0] fails;
  assign fails = {pll_clock_fail_i, highway_a_clock_fail_i, highway_b_clock_fail_i};
  // Mirror of the mask, so checks need no hierarchy
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mask_copy <= 16'h7FFF;
    end else if (reg_write_i && reg_addr_i == 8'h0D) begin
      mask_copy <= reg_wdata_i;
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      boot_cnt <= 16'h0000;
    end else if (boot_cnt != 16'hFFFF) begin
      boot_cnt <= boot_cnt + 16'h0001;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_ovf_raise: assert property (event_discard_i && !mask_copy[14] |=> system_interrupt_o)
    else $error("overflow did not raise interrupt");
  a_wdt_raise: assert property ($fell(watchdog_output_pin_i) && !system_reset_i
    && !mask_copy[13] |=> system_interrupt_o)
    else $error("watchdog edge did not raise interrupt");
  a_int_pin: assert property (system_interrupt_o |-> !host_interrupt_n_o)
    else $error("system interrupt not on pin");
  a_defer_off: assert property (!mask_copy[15] && queue23_pending_i |-> !host_interrupt_n_o)
    else $error("low queue not reported");
  a_defer_hold: assert property (mask_copy[15] && $past(host_interrupt_n_o)
    && !queue1_pending_i && !system_interrupt_o |-> host_interrupt_n_o)
    else $error("deferred queue drove pin");
  a_mask_all: assert property (&mask_copy[14:0] |-> !system_interrupt_o)
    else $error("masked source interrupted");
  a_hold_boot: assert property (boot_cnt < SETTLE_CYCLES |-> core_hold_o)
    else $error("core released before settle");
  a_mask_read: assert property (reg_read_i && reg_addr_i == 8'h0D |=> reg_rdata_o == mask_copy)
    else $error("mask readback wrong");
  a_fail_live: assert property (reg_read_i && reg_addr_i == 8'h0C && $stable(fails)
    |=> {reg_rdata_o[15], reg_rdata_o[12:10]} == {1'b0, $past(fails)})
    else $error("clock fail status wrong");
  a_entry_high: assert property (reg_write_i && reg_addr_i == 8'h18
    |=> program_entry_address_o[31:16] == $past(reg_wdata_i))
    else $error("entry high not taken");
  c_ovf: cover property (event_discard_i && !mask_copy[14]);
  c_release: cover property (mask_copy[15] && $rose(low_queue_release_o));
  c_boot: cover property ($fell(core_hold_o));
endmodule
bind ssbc_system_regs ssbc_system_regs_asserts #(.SETTLE_CYCLES(SETTLE_CYCLES))
  i_ssbc_system_regs_asserts (.*);

// ===== tb/ssbc_host_model.sv
`timescale 1ns/10ps
module ssbc_host_model (
  input wire logic clk_i,
  input wire logic [15:0] reg_rdata_i,
  output logic [7:0] reg_addr_o,
  output logic [15:0] reg_wdata_o,
  output logic reg_write_o,
  output logic reg_read_o
);
  initial begin
    reg_addr_o = 8'h00;
    reg_wdata_o = 16'h0000;
    reg_write_o = 1'b0;
    reg_read_o = 1'b0;
  end
  // image goes out one whole word per strobe
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_write_o <= 1'b1;
    @(posedge clk_i);
    reg_write_o <= 1'b0;
    // Stale data would hide a missed strobe
    reg_wdata_o <= ~d;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_i);
    reg_addr_o <= a;
    reg_read_o <= 1'b1;
    @(posedge clk_i);
    reg_read_o <= 1'b0;
    #1 d = reg_rdata_i;
  endtask
  task automatic entry(input logic [31:0] ea);
    wr(8'h18, ea[31:16]);
    wr(8'h19, ea[15:0]);
  endtask
endmodule

// ===== tb/ssbc_system_regs_bench.sv
`timescale 1ns/10ps
`define CK(a, b) begin total_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module ssbc_system_regs_bench;
  import ssbc_pkg::*;
  localparam int SETTLE = 4;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] reg_addr_i;
  logic [15:0] reg_wdata_i;
  logic reg_write_i;
  logic reg_read_i;
  logic [15:0] reg_rdata_o;
  logic interrupt_indication_read_i = 1'b0;
  logic event_discard_i = 1'b0;
  logic queue1_pending_i = 1'b0;
  logic queue23_pending_i = 1'b0;
  logic watchdog_output_pin_i = 1'b1;
  logic system_reset_i = 1'b0;
  logic pll_clock_fail_i = 1'b1;
  logic highway_a_clock_fail_i = 1'b1;
  logic highway_b_clock_fail_i = 1'b1;
  logic [31:0] gpio_i;
  logic [3:0] reset_cause_bits_i;
  logic selftest_done_i = 1'b0;
  logic debug_release_i = 1'b0;
  logic host_interrupt_n_o;
  logic low_queue_release_o;
  logic system_interrupt_o;
  logic core_hold_o;
  logic pll_max_speed_o;
  logic selftest_start_o;
  logic debug_mode_o;
  logic uart_cli_enable_o;
  logic gpio_messages_enable_o;
  logic [31:0] program_entry_address_o;
  int error_cnt = 0;
  int total_checks = 0;
  int i;
  logic [31:0] g;
  logic [3:0] rc;
  logic [2:0] f;
  logic [15:0] st;
  logic [9:0] sw;
  logic [31:0] ea;
  always #50 clk_i = ~clk_i;
  ssbc_system_regs #(.SETTLE_CYCLES(SETTLE)) i_ssbc_system_regs (.*);
  ssbc_host_model i_ssbc_host_model (.clk_i(clk_i), .reg_rdata_i(reg_rdata_o),
    .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i), .reg_write_o(reg_write_i),
    .reg_read_o(reg_read_i));
  task automatic rchk(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] d;
    i_ssbc_host_model.rd(a, d);
    `CK(d, e)
  endtask
  task automatic ovf;
    @(posedge clk_i);
    event_discard_i <= 1'b1;
    @(posedge clk_i);
    event_discard_i <= 1'b0;
    #1;
  endtask
  task automatic ind;
    @(posedge clk_i);
    interrupt_indication_read_i <= 1'b1;
    @(posedge clk_i);
    interrupt_indication_read_i <= 1'b0;
    #1;
  endtask
  task automatic q23(input logic v);
    @(posedge clk_i);
    queue23_pending_i <= v;
    @(posedge clk_i);
    #1;
  endtask
  task end_sim;
    $display("errors %0d checks %0d", error_cnt, total_checks);
    if (error_cnt == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #200000;
    error_cnt++;
    end_sim();
  end
  initial begin
    i = $urandom(83737);
    g = $urandom;
    // Straps chosen so boot needs no self-test or debug release
    g[30:28] = 3'b110;
    rc = 4'($urandom);
    gpio_i = g;
    reset_cause_bits_i = rc;
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    #1 `CK(core_hold_o, 1'b1)
    for (i = 0; i < 100 && core_hold_o !== 1'b0; i++) begin
      @(posedge clk_i);
      #1;
    end
    `CK(core_hold_o, 1'b0)
    `CK({pll_max_speed_o, uart_cli_enable_o, gpio_messages_enable_o}, {!g[31], 2'b00})
    `CK(i >= SETTLE, 1'b1)
    rchk(8'h1B, {13'h0000, SSBC_DONE});
    rchk(8'h14, g[31:16]);
    rchk(8'h15, g[15:0]);
    rchk(8'h16, {12'h000, rc});
    rchk(8'h0D, 16'h7FFF);
    rchk(8'h0C, 16'h1C00);
    rchk(8'h3F, 16'h0000);
    f = 3'($urandom);
    st = {3'b000, f, 10'h000};
    @(posedge clk_i);
    {pll_clock_fail_i, highway_a_clock_fail_i, highway_b_clock_fail_i} <= f;
    i_ssbc_host_model.wr(8'h0C, 16'hFFFF);
    rchk(8'h0C, st);
    ovf();
    `CK(system_interrupt_o, 1'b0)
    rchk(8'h0C, st | 16'h4000);
    rchk(8'h0C, st);
    i_ssbc_host_model.wr(8'h0D, 16'h1FFF);
    ovf();
    `CK(host_interrupt_n_o, 1'b0)
    rchk(8'h0C, st | 16'h4000);
    ind();
    `CK(system_interrupt_o, 1'b0)
    @(posedge clk_i);
    system_reset_i <= 1'b1;
    watchdog_output_pin_i <= 1'b0;
    @(posedge clk_i);
    system_reset_i <= 1'b0;
    watchdog_output_pin_i <= 1'b1;
    #1 `CK(system_interrupt_o, 1'b0)
    @(posedge clk_i);
    watchdog_output_pin_i <= 1'b0;
    @(posedge clk_i);
    #1 `CK(system_interrupt_o, 1'b1)
    rchk(8'h0C, st | 16'h2000);
    ind();
    `CK(system_interrupt_o, 1'b0)
    i_ssbc_host_model.wr(8'h0D, 16'h9FFF);
    q23(1'b1);
    `CK({host_interrupt_n_o, low_queue_release_o}, 2'b10)
    @(posedge clk_i);
    queue1_pending_i <= 1'b1;
    @(posedge clk_i);
    queue1_pending_i <= 1'b0;
    #1 `CK(host_interrupt_n_o, 1'b0)
    @(posedge clk_i);
    #1 `CK({host_interrupt_n_o, low_queue_release_o}, 2'b01)
    q23(1'b0);
    `CK(host_interrupt_n_o, 1'b1)
    i_ssbc_host_model.wr(8'h0D, 16'h1FFF);
    q23(1'b1);
    `CK(host_interrupt_n_o, 1'b0)
    q23(1'b0);
    ea = $urandom;
    i_ssbc_host_model.entry(ea);
    `CK(program_entry_address_o, ea)
    rchk(8'h19, ea[15:0]);
    rchk(8'h18, ea[31:16]);
    sw = 10'($urandom) | 10'h001;
    i_ssbc_host_model.wr(8'h1A, {6'h00, sw});
    `CK(system_interrupt_o, 1'b0)
    rchk(8'h0C, st | {6'h00, sw});
    i_ssbc_host_model.wr(8'h0D, 16'h1C00);
    `CK(system_interrupt_o, 1'b1)
    // Mid-run reset: straps now ask for clock wait, self-test and debug stop
    g = $urandom;
    g[31:28] = 4'b0001;
    rc = 4'($urandom);
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    gpio_i <= g;
    reset_cause_bits_i <= rc;
    pll_clock_fail_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (SETTLE + 6) @(posedge clk_i);
    #1 `CK({core_hold_o, pll_max_speed_o}, 2'b11)
    `CK({uart_cli_enable_o, gpio_messages_enable_o}, g[27:26])
    rchk(8'h1B, {13'h0000, SSBC_CLOCK_WAIT});
    rchk(8'h14, g[31:16]);
    rchk(8'h16, {12'h000, rc});
    @(posedge clk_i);
    pll_clock_fail_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1 `CK(selftest_start_o, 1'b1)
    @(posedge clk_i);
    selftest_done_i <= 1'b1;
    #1 `CK({selftest_start_o, core_hold_o}, 2'b01)
    @(posedge clk_i);
    selftest_done_i <= 1'b0;
    #1 `CK(debug_mode_o, 1'b1)
    @(posedge clk_i);
    debug_release_i <= 1'b1;
    #1 `CK({debug_mode_o, core_hold_o}, 2'b11)
    @(posedge clk_i);
    debug_release_i <= 1'b0;
    #1 `CK({debug_mode_o, core_hold_o}, 2'b00)
    `CK({uart_cli_enable_o, gpio_messages_enable_o}, 2'b00)
    end_sim();
  end
endmodule
